// ### hdl/tfm_irq.sv
// flag and mask logic for both 16-bit timers with wishbone slave
//
// Contract
// - cmp A request when enabled and global on
// - overflow request when enabled and global on
// - capture pin event sets capture flag
// - capture-as-top mode: flag sets at top
// - capture flag cleared by vector or one
// - compare flags set cycle after match
// - forced compare never sets a flag
// - compare flags cleared by vector or one
// - overflow flag set per waveform mode
// - overflow flag cleared by vector or one
// - reserved flag bits read zero
// - capture request when enabled and global on
// - cmp C request when enabled and global on
// - cmp B request when enabled and global on
`timescale 1ns/1ns
`include "tfm_consts.svh"

module tfm_irq (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // timer events and vector acknowledges
    input wire tfm_pkg::tfm_evt_s evt1_i,
    input wire tfm_pkg::tfm_evt_s evt3_i,
    input wire tfm_pkg::tfm_ack_s vack1_i,
    input wire tfm_pkg::tfm_ack_s vack3_i,
    // requests to the core
    output tfm_pkg::tfm_ack_s req1_o,
    output tfm_pkg::tfm_ack_s req3_o,
    output logic irq_o
);

    // ************************************************************
    // helper functions
    // ************************************************************
    // hardware set sources from the events
    function automatic tfm_pkg::tfm_byte_t set_bits(
        input tfm_pkg::tfm_evt_s e
    );
        tfm_pkg::tfm_byte_t s;
        s = 8'h00;
        // pin disconnected when capture register is top
        s[`TFM_BIT_CAP] = e.capture_is_top ? e.top_reached
                                           : e.capture_pin;
        // match pulse arrives in the cycle it occurs; flag lands next
        s[`TFM_BIT_CMPA] = e.cmp_a_match;
        s[`TFM_BIT_CMPB] = e.cmp_b_match;
        s[`TFM_BIT_CMPC] = e.cmp_c_match;
        // outside normal and ctc, the counter qualifies the overflow
        s[`TFM_BIT_OVF] = e.overflow;
        return s;
    endfunction : set_bits

    function automatic tfm_pkg::tfm_byte_t ack_bits(
        input tfm_pkg::tfm_ack_s a
    );
        tfm_pkg::tfm_byte_t c;
        c = 8'h00;
        c[`TFM_BIT_CAP] = a.capture;
        c[`TFM_BIT_CMPC] = a.cmp_c;
        c[`TFM_BIT_CMPB] = a.cmp_b;
        c[`TFM_BIT_CMPA] = a.cmp_a;
        c[`TFM_BIT_OVF] = a.overflow;
        return c;
    endfunction : ack_bits

    function automatic tfm_pkg::tfm_ack_s pick(
        input tfm_pkg::tfm_byte_t v
    );
        tfm_pkg::tfm_ack_s r;
        r.capture = v[`TFM_BIT_CAP];
        r.cmp_c = v[`TFM_BIT_CMPC];
        r.cmp_b = v[`TFM_BIT_CMPB];
        r.cmp_a = v[`TFM_BIT_CMPA];
        r.overflow = v[`TFM_BIT_OVF];
        return r;
    endfunction : pick

    // ************************************************************
    // bus decode
    // ************************************************************
    logic wr_stb;
    logic rd_stb;
    tfm_pkg::tfm_byte_t flags_r [2];
    tfm_pkg::tfm_byte_t mask_r [2];
    tfm_pkg::tfm_byte_t set_v [2];
    tfm_pkg::tfm_byte_t clr_v [2];
    logic gie_r;
    logic [31:0] rd_nxt;

    // ack_o gating stops a held request being taken twice
    assign wr_stb = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign rd_stb = cyc_i && stb_i && !ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_comb begin
        rd_nxt = 32'h00000000;
        unique case (adr_i)
            `TFM_T1_FLAGS_OFS: rd_nxt[7:0] = flags_r[0];
            `TFM_T1_MASK_OFS: rd_nxt[7:0] = mask_r[0];
            `TFM_T3_FLAGS_OFS: rd_nxt[7:0] = flags_r[1];
            `TFM_T3_MASK_OFS: rd_nxt[7:0] = mask_r[1];
            `TFM_CTRL_OFS: rd_nxt[0] = gie_r;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd_stb) begin
            dat_o <= rd_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gie_r <= 1'b0;
        end else if (wr_stb && adr_i == `TFM_CTRL_OFS) begin
            gie_r <= dat_i[0];
        end
    end

    // ************************************************************
    // per timer flags and masks
    // ************************************************************
    // one body, two copies: timer 1 at index 0, timer 3 at index 1
    always_comb begin
        set_v[0] = set_bits(evt1_i);
        set_v[1] = set_bits(evt3_i);
        clr_v[0] = ack_bits(vack1_i);
        clr_v[1] = ack_bits(vack3_i);
        // only ones written clear; zeros leave flags alone
        if (wr_stb && adr_i == `TFM_T1_FLAGS_OFS) begin
            clr_v[0] = clr_v[0] | dat_i[7:0];
        end
        if (wr_stb && adr_i == `TFM_T3_FLAGS_OFS) begin
            clr_v[1] = clr_v[1] | dat_i[7:0];
        end
    end

    for (genvar t = 0; t < 2; t++) begin : g_tmr
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                flags_r[t] <= `TFM_RESET_VAL;
            end else begin
                // set is or-ed last so a same cycle event survives
                flags_r[t] <= ((flags_r[t] & ~clr_v[t]) | set_v[t])
                              & `TFM_IMPL_MASK;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mask_r[t] <= `TFM_RESET_VAL;
            end else if (wr_stb && adr_i == (t == 0 ? `TFM_T1_MASK_OFS
                                                    : `TFM_T3_MASK_OFS)) begin
                mask_r[t] <= dat_i[7:0] & `TFM_IMPL_MASK;
            end
        end
    end

    // ************************************************************
    // requests
    // ************************************************************
    // registered: a request lags its flag by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req1_o <= '0;
            req3_o <= '0;
            irq_o <= 1'b0;
        end else begin
            req1_o <= pick(flags_r[0] & mask_r[0] & {8{gie_r}});
            req3_o <= pick(flags_r[1] & mask_r[1] & {8{gie_r}});
            irq_o <= gie_r && (|(flags_r[0] & mask_r[0])
                               || |(flags_r[1] & mask_r[1]));
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_cmpa_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req1_o.cmp_a == $past(flags_r[0][1] && mask_r[0][1] && gie_r))
        else $error("cmp a request wrong");
    a_ovf_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req3_o.overflow == $past(flags_r[1][0] && mask_r[1][0] && gie_r))
        else $error("overflow request wrong");
    a_cap_set: assert property (@(posedge clk_i) disable iff (rst_i)
        evt1_i.capture_pin && !evt1_i.capture_is_top |=> flags_r[0][5])
        else $error("capture flag not set");
    a_cap_top: assert property (@(posedge clk_i) disable iff (rst_i)
        evt1_i.capture_is_top && !evt1_i.top_reached && !$past(rst_i)
        && !flags_r[0][5] |=> !flags_r[0][5] || $past(evt1_i.top_reached))
        else $error("capture flag set from pin in top mode");
    a_cap_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        vack1_i.capture && !set_v[0][5] |=> !flags_r[0][5])
        else $error("capture flag not cleared");
    a_cmp_set: assert property (@(posedge clk_i) disable iff (rst_i)
        evt3_i.cmp_b_match ##1 1'b1 |-> flags_r[1][2])
        else $error("compare flag not set");
    a_force_none: assert property (@(posedge clk_i) disable iff (rst_i)
        evt1_i.force_cmp_c && !evt1_i.cmp_c_match && !flags_r[0][3]
        |=> !flags_r[0][3])
        else $error("forced compare set flag");
    a_sw_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stb && adr_i == `TFM_T3_FLAGS_OFS && dat_i[1]
        && !set_v[1][1] |=> !flags_r[1][1])
        else $error("write one did not clear");
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (flags_r[0] & ~`TFM_IMPL_MASK) == 8'h00
        && (flags_r[1] & ~`TFM_IMPL_MASK) == 8'h00)
        else $error("reserved flag bit set");
    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        evt3_i.overflow && vack3_i.overflow |=> flags_r[1][0])
        else $error("set lost to clear");
    a_cmpb_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req3_o.cmp_b == $past(flags_r[1][2] && mask_r[1][2] && gie_r))
        else $error("cmp b request wrong");
    a_cmpc_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req1_o.cmp_c == $past(flags_r[0][3] && mask_r[0][3] && gie_r))
        else $error("cmp c request wrong");
    a_cap_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req3_o.capture == $past(flags_r[1][5] && mask_r[1][5] && gie_r))
        else $error("capture request wrong");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == $past(gie_r && (|(flags_r[0] & mask_r[0])
                                 || |(flags_r[1] & mask_r[1]))))
        else $error("interrupt level wrong");
    a_ovf_set: assert property (@(posedge clk_i) disable iff (rst_i)
        evt1_i.overflow |=> flags_r[0][0])
        else $error("overflow flag not set");
    a_ovf_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        vack3_i.overflow && !set_v[1][0] |=> !flags_r[1][0])
        else $error("overflow flag not cleared");
    a_cmpa_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        vack1_i.cmp_a && !set_v[0][1] |=> !flags_r[0][1])
        else $error("compare flag not cleared by vector");
    a_t3_cap_set: assert property (@(posedge clk_i) disable iff (rst_i)
        evt3_i.capture_pin && !evt3_i.capture_is_top |=> flags_r[1][5])
        else $error("timer 3 capture flag not set");
    a_t3_force: assert property (@(posedge clk_i) disable iff (rst_i)
        evt3_i.force_cmp_a && !evt3_i.cmp_a_match && !flags_r[1][1]
        |=> !flags_r[1][1])
        else $error("timer 3 forced compare set flag");
    a_zero_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stb && adr_i == `TFM_T1_FLAGS_OFS && dat_i[7:0] == 8'h00
        && vack1_i == '0
        |=> flags_r[0] == ($past(flags_r[0] | set_v[0]) & `TFM_IMPL_MASK))
        else $error("zero write changed a flag");
    a_mask_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
        ((mask_r[0] | mask_r[1]) & ~`TFM_IMPL_MASK) == 8'h00)
        else $error("reserved mask bit set");
    a_rd_high: assert property (@(posedge clk_i) disable iff (rst_i)
        dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_reset_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> flags_r[0] == 8'h00 && flags_r[1] == 8'h00
        && mask_r[0] == 8'h00 && mask_r[1] == 8'h00 && !gie_r)
        else $error("state not zero after reset");

endmodule : tfm_irq

// ### hdl/tfm_consts.svh
// constants for the timer interrupt flag and mask block
`ifndef TFM_CONSTS_SVH
`define TFM_CONSTS_SVH
// register byte offsets
`define TFM_T1_FLAGS_OFS 8'h00
`define TFM_T1_MASK_OFS 8'h04
`define TFM_T3_FLAGS_OFS 8'h08
`define TFM_T3_MASK_OFS 8'h0c
`define TFM_CTRL_OFS 8'h10
// field positions
`define TFM_BIT_OVF 0
`define TFM_BIT_CMPA 1
`define TFM_BIT_CMPB 2
`define TFM_BIT_CMPC 3
`define TFM_BIT_CAP 5
`define TFM_IMPL_MASK 8'h2f
`define TFM_RESET_VAL 8'h00
`endif

// ### hdl/tfm_pkg.sv
// types for the timer interrupt flag and mask block
package tfm_pkg;
    // per timer hardware events, one cycle pulses
    typedef struct packed {
        logic capture_pin;
        logic top_reached;
        logic capture_is_top;
        logic cmp_a_match;
        logic cmp_b_match;
        logic cmp_c_match;
        logic force_cmp_a;
        logic force_cmp_b;
        logic force_cmp_c;
        logic overflow;
        logic overflow_mode;
    } tfm_evt_s;
    // vector acknowledge from the core, one bit per source
    typedef struct packed {
        logic capture;
        logic cmp_c;
        logic cmp_b;
        logic cmp_a;
        logic overflow;
    } tfm_ack_s;
    typedef logic [7:0] tfm_byte_t;
endpackage : tfm_pkg

// ### test/tfm_core_model.sv
// core model that executes the vector of any pending request
`timescale 1ns/1ns
module tfm_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic auto_ack_i,
    // requests in, vector acknowledges out
    input wire tfm_pkg::tfm_ack_s req1_i,
    input wire tfm_pkg::tfm_ack_s req3_i,
    output tfm_pkg::tfm_ack_s vack1_o,
    output tfm_pkg::tfm_ack_s vack3_o
);
    // a pulse every other cycle while a request is held; requests lag flags, so repeats are harmless
    always_ff @(posedge clk_i) begin
        if (rst_i || !auto_ack_i) begin
            vack1_o <= '0;
            vack3_o <= '0;
        end else begin
            vack1_o <= tfm_pkg::tfm_ack_s'(req1_i & ~vack1_o);
            vack3_o <= tfm_pkg::tfm_ack_s'(req3_i & ~vack3_o);
        end
    end
endmodule : tfm_core_model

// ### test/testbench.sv
// self-checking bench for the timer flag and mask block
`timescale 1ns/1ns
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic auto_ack = 1'b0;
    tfm_pkg::tfm_evt_s evt1_i = '0;
    tfm_pkg::tfm_evt_s evt3_i = '0;
    tfm_pkg::tfm_ack_s vack1_i, vack3_i, req1_o, req3_o;
    int errors = 0;
    int checked = 0;
    int ks[5] = '{0, 1, 2, 3, 5};
    always #10 clk_i = ~clk_i;
    tfm_irq i_tfm_irq (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .evt1_i(evt1_i),
        .evt3_i(evt3_i), .vack1_i(vack1_i), .vack3_i(vack3_i),
        .req1_o(req1_o), .req3_o(req3_o), .irq_o(irq_o));
    tfm_core_model i_tfm_core_model (.clk_i(clk_i), .rst_i(rst_i),
        .auto_ack_i(auto_ack), .req1_i(req1_o), .req3_i(req3_o),
        .vack1_o(vack1_i), .vack3_o(vack3_i));
    task automatic results;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // classic single cycle; waits are bounded so a dead slave ends the run
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 10);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (n >= 10) begin
            errors++;
            results();
        end
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, q);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, {24'h0, e}, q);
    endtask : rd
    task automatic pulse(input int t, input tfm_pkg::tfm_evt_s e);
        @(posedge clk_i);
        if (t == 1) evt3_i <= e; else evt1_i <= e;
        @(posedge clk_i);
        evt1_i <= '0;
        evt3_i <= '0;
    endtask : pulse
    function automatic tfm_pkg::tfm_evt_s ev(input int k);
        tfm_pkg::tfm_evt_s e;
        e = '0;
        case (k)
            0: e.overflow = 1'b1;
            1: e.cmp_a_match = 1'b1;
            2: e.cmp_b_match = 1'b1;
            3: e.cmp_c_match = 1'b1;
            default: e.capture_pin = 1'b1;
        endcase
        return e;
    endfunction : ev
    // each source sets its own bit; zero writes keep it, a one clears it
    task automatic s_set(input int t);
        logic [7:0] f;
        f = t ? 8'h08 : 8'h00;
        foreach (ks[i]) begin
            pulse(t, ev(ks[i]));
            rd("flag set", f, 8'h01 << ks[i]);
            wr(f, 8'h00);
            rd("zero write", f, 8'h01 << ks[i]);
            wr(f, 8'h01 << ks[i]);
            rd("one clear", f, 8'h00);
        end
    endtask : s_set
    task automatic s_force(input int t);
        tfm_pkg::tfm_evt_s e;
        logic [7:0] f;
        f = t ? 8'h08 : 8'h00;
        e = '0;
        e.force_cmp_a = 1'b1;
        e.force_cmp_b = 1'b1;
        e.force_cmp_c = 1'b1;
        pulse(t, e);
        rd("forced", f, 8'h00);
        e = '0;
        e.capture_is_top = 1'b1;
        e.capture_pin = 1'b1;
        pulse(t, e);
        rd("pin at top", f, 8'h00);
        e.top_reached = 1'b1;
        pulse(t, e);
        rd("top capture", f, 8'h20);
        wr(f, 8'hff);
        rd("reserved", f, 8'h00);
        wr(f + 8'h04, 8'hff);
        rd("mask bits", f + 8'h04, 8'h2f);
    endtask : s_force
    // the request of each source follows its flag with mask bit and global enable on; clearing the mask bit drops irq_o
    task automatic s_irq(input int t);
        logic [7:0] f;
        f = t ? 8'h08 : 8'h00;
        wr(8'h10, 8'h01);
        foreach (ks[i]) begin
            wr(f + 8'h04, 8'h01 << ks[i]);
            pulse(t, ev(ks[i]));
            rd("flag", f, 8'h01 << ks[i]);
            chk("req", 32'(ks[i] == 5 ? 5'h10 : 5'h01 << ks[i]),
                32'(t ? req3_o : req1_o));
            chk("irq", 32'h1, 32'(irq_o));
            wr(f + 8'h04, 8'h00);
            rd("masked", f, 8'h01 << ks[i]);
            chk("irq masked", 32'h0, 32'(irq_o));
            wr(f, 8'hff);
        end
        wr(8'h10, 8'h00);
    endtask : s_irq
    task automatic s_vector(input int t);
        logic [7:0] f;
        f = t ? 8'h08 : 8'h00;
        auto_ack <= 1'b1;
        wr(f + 8'h04, 8'h2f);
        wr(8'h10, 8'h01);
        foreach (ks[i]) begin
            pulse(t, ev(ks[i]));
            repeat (6) @(posedge clk_i);
            rd("vector clear", f, 8'h00);
        end
        chk("irq idle", 32'h0, 32'(irq_o));
        wr(8'h10, 8'h00);
        auto_ack <= 1'b0;
    endtask : s_vector
    // a mid-run reset must drop irq_o and zero the timer 1 flags, the timer 1 mask and the global enable
    task automatic s_reset;
        wr(8'h04, 8'h2f);
        wr(8'h10, 8'h01);
        pulse(0, ev(1));
        repeat (2) @(posedge clk_i);
        chk("irq before reset", 32'h1, 32'(irq_o));
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("irq in reset", 32'h0, 32'(irq_o));
        rd("flags after reset", 8'h00, 8'h00);
        rd("mask after reset", 8'h04, 8'h00);
        rd("gie after reset", 8'h10, 8'h00);
    endtask : s_reset
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 24; a += 4) begin
            rd("reset", 8'(a), 8'h00);
        end
        for (int t = 0; t < 2; t++) begin
            s_set(t);
            s_force(t);
            s_irq(t);
            s_vector(t);
        end
        s_reset();
        results();
    end
endmodule : testbench
